// ---- dv/amf_drive_model.sv ----
`timescale 1ns/1ns
// ****************************************
// drive side: byte clock, index, capture
// ****************************************
module amf_drive_model #(
	parameter int REV_BYTES = 120, // bytes per revolution, shortened to keep runs short
	parameter int HALF_NS   = 41   // half byte period, unrelated in phase to clk_sys
) (
	// drive pins
	output logic            byte_clk,
	output logic            index_in,
	// controller pins
	input  wire logic       write_gate,
	input  wire logic       erase_cmd,
	input  wire logic [7:0] write_byte
);
	logic [7:0] got[$]; // bytes recorded while the gate is open
	int         erase_n; // erasure bytes made by the drive
	int         byte_n;  // byte position within a revolution
	logic       erase_last; // erasure requested at the previous byte
	int         mark_n;  // marks a later search would flag
	// write clock runs free, as the servo track derives it
	initial begin
		byte_clk = 1'b0;
		index_in = 1'b0;
		erase_n  = 0;
		byte_n   = 0;
		erase_last = 1'b0;
		mark_n   = 0;
		forever begin
			#HALF_NS byte_clk = ~byte_clk;
		end
	end
	// the controller changes data on the rising edge, so each edge sees the last byte
	always @(posedge byte_clk) begin
		byte_n   <= (byte_n + 1) % REV_BYTES;
		index_in <= (byte_n < 4);
		if (erase_cmd === 1'b1) begin
			erase_n <= erase_n + 1;
		end
		// the end of an erasure run is one recorded mark that a search would report
		erase_last <= (erase_cmd === 1'b1);
		if (erase_last && erase_cmd !== 1'b1) begin
			mark_n <= mark_n + 1;
		end
		if (write_gate === 1'b1) begin
			got.push_back(write_byte);
		end
	end
endmodule : amf_drive_model

// ---- dv/amf_track_writer_bench.sv ----
`timescale 1ns/1ns
module amf_track_writer_bench;
	import amf_pkg::*;
	localparam int IDL = 4;  // identifier bytes
	localparam int DTL = 16; // data and check bytes
	logic clk_sys, rstn, start, update_only, use_header, user_take, busy;
	logic byte_clk, index_in, write_gate, erase_cmd;
	logic [7:0]  user_byte, write_byte;
	logic [15:0] max_sectors;
	amf_fmt_e    fmt;
	logic [7:0]  ub[64];  // random user bytes
	logic [7:0]  ex[$];   // expected byte stream
	int          ui, ers, k, fails, checks;
	amf_track_writer #(.ID_LEN(16'd4), .DATA_LEN(16'd16)) u_dut (
		.clk_sys(clk_sys), .rstn(rstn), .start(start), .update_only(update_only),
		.use_header(use_header), .fmt(fmt), .user_byte(user_byte), .user_take(user_take),
		.busy(busy), .max_sectors(max_sectors), .byte_clk(byte_clk), .index_in(index_in),
		.write_gate(write_gate), .erase_cmd(erase_cmd), .write_byte(write_byte));
	amf_drive_model u_drv (.byte_clk(byte_clk), .index_in(index_in),
		.write_gate(write_gate), .erase_cmd(erase_cmd), .write_byte(write_byte));
	initial begin
		clk_sys = 1'b0;
		forever begin
			#5 clk_sys = ~clk_sys;
		end
	end
	// next user byte once the writer has taken one
	always @(posedge clk_sys) begin
		if (user_take === 1'b1) begin
			k++;
			#1 user_byte = ub[k % 64];
		end
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic report_and_stop();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop
	function automatic void fill(input int n, input logic [7:0] v);
		repeat (n) ex.push_back(v);
	endfunction : fill
	function automatic void users(input int n);
		repeat (n) begin
			ex.push_back(ub[ui % 64]);
			ui++;
		end
	endfunction : users
	// capacity: track less track overhead and header, over the sector size
	function automatic logic [15:0] cap(input amf_fmt_e f, input logic h);
		int oh[4] = '{44, 32, 30, 18};
		int tr;
		tr = (f < AMF_FMT_E) ? 16 : 30;
		return 16'((20160 - tr - (h ? 32 + IDL : 0)) / (oh[f] + IDL + DTL));
	endfunction : cap
	task automatic run_rec(input amf_fmt_e f, input logic h, input logic u);
		int n;
		ex = {};
		ui = 0;
		ers = 0;
		if (h) begin
			fill(16, 8'h00);
			ers += 3;
			fill(11, 8'h00);
			fill(1, 8'hff);
			users(IDL);
			fill(1, 8'h00);
		end
		if (!(u && f == AMF_FMT_C)) begin
			ers += 3;
		end
		case (f)
			AMF_FMT_C: begin
				if (!u) begin
					fill(11, 8'h00);
					fill(1, 8'hff);
					users(IDL);
					fill(1, 8'h00);
				end
				fill(11, 8'h00);
				users(DTL);
				fill(1, 8'h00);
				fill(15, 8'h00);
			end
			AMF_FMT_D: begin
				users(IDL + DTL);
				fill(1, 8'h00);
				fill(15, 8'h00);
			end
			AMF_FMT_E: begin
				fill(1, 8'h00);
				fill(11, 8'h00);
				fill(1, 8'hff);
				users(IDL);
				fill(11, 8'h00);
				users(DTL);
				fill(2, 8'h00);
				fill(14, 8'h00);
			end
			default: begin
				fill(1, 8'h00);
				users(IDL + DTL);
				fill(2, 8'h00);
				fill(14, 8'h00);
			end
		endcase
		u_drv.got = {};
		u_drv.erase_n = 0;
		u_drv.mark_n = 0;
		k = 0;
		@(posedge clk_sys);
		#1 user_byte = ub[0];
		fmt = f;
		use_header = h;
		update_only = u;
		start = 1'b1;
		@(posedge clk_sys);
		#1 start = 1'b0;
		repeat (20) @(posedge clk_sys);
		#1 start = 1'b1; // ignored while busy
		@(posedge clk_sys);
		#1 start = 1'b0;
		n = 0;
		while (busy !== 1'b0 && n < 30000) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 30000) begin
			fails++;
			report_and_stop();
		end
		repeat (40) @(posedge clk_sys);
		check("byte count", 16'(u_drv.got.size()), 16'(ex.size()));
		for (int i = 0; i < ex.size() && i < u_drv.got.size(); i++) begin
			check("byte", {8'h00, u_drv.got[i]}, {8'h00, ex[i]});
		end
		check("erase bytes", 16'(u_drv.erase_n), 16'(ers));
		check("marks", 16'(u_drv.mark_n), 16'(ers / 3));
		check("max sectors", max_sectors, cap(f, h));
		$display("test fmt %0d hdr %0d upd %0d done", f, h, u);
	endtask : run_rec
	initial begin
		rstn = 1'b0;
		start = 1'b0;
		update_only = 1'b0;
		use_header = 1'b0;
		fmt = AMF_FMT_C;
		user_byte = 8'h00;
		fails = 0;
		checks = 0;
		k = 0;
		void'($urandom(32'h8b4f868b));
		foreach (ub[i]) ub[i] = 8'($urandom);
		repeat (16) @(posedge clk_sys);
		#1 rstn = 1'b1;
		for (int i = 0; i < 8; i++) begin
			run_rec(amf_fmt_e'(i % 4), 1'(i / 4), 1'b0);
		end
		run_rec(AMF_FMT_C, 1'b0, 1'b1);
		run_rec(AMF_FMT_E, 1'b0, 1'b1);
		repeat (3) run_rec(amf_fmt_e'($urandom % 4), 1'($urandom), 1'b0);
		report_and_stop();
	end
endmodule : amf_track_writer_bench

// ---- logic/amf_map.svh ----
`ifndef AMF_MAP_SVH
`define AMF_MAP_SVH
// field lengths in bytes
`define AMF_HDR_PRE_LEN   16'd16
`define AMF_ERASE_LEN     16'd3
`define AMF_LOCK_LEN      16'd11
`define AMF_RELOCK_LEN    16'd11
`define AMF_SYNC_LEN      16'd1
`define AMF_SPLICE_LEN    16'd1
`define AMF_PAD_SEQ_LEN   16'd1
`define AMF_PAD_ILV_LEN   16'd2
`define AMF_TRAIL_SEQ_LEN 16'd15
`define AMF_TRAIL_ILV_LEN 16'd14
`define AMF_HDR_PAD_LEN   16'd1
// per-sector overhead and per-track overhead
`define AMF_OH_C          16'd44
`define AMF_OH_D          16'd32
`define AMF_OH_E          16'd30
`define AMF_OH_F          16'd18
`define AMF_TRK_OH_CD     16'd16
`define AMF_TRK_OH_EF     16'd30
`define AMF_TRACK_LEN     16'd20160
// fill byte values
`define AMF_ZERO_BYTE     8'h00
`define AMF_ONES_BYTE     8'hff
`endif

// ---- logic/amf_pkg.sv ----
package amf_pkg;
	// record layout choice
	typedef enum logic [1:0] {
		AMF_FMT_C = 2'b00,  // consecutive, fixed identifier
		AMF_FMT_D = 2'b01,  // consecutive, identifier rewritten
		AMF_FMT_E = 2'b10,  // interlaced, fixed identifier
		AMF_FMT_F = 2'b11   // interlaced, identifier rewritten
	} amf_fmt_e;
	// sequencer field states
	typedef enum logic [3:0] {
		AMF_ST_IDLE   = 4'b0000,
		AMF_ST_PRE    = 4'b0001,
		AMF_ST_ERASE  = 4'b0010,
		AMF_ST_SPLICE = 4'b0011,
		AMF_ST_LOCK   = 4'b0100,
		AMF_ST_SYNC   = 4'b0101,
		AMF_ST_IDENT  = 4'b0110,
		AMF_ST_RELOCK = 4'b0111,
		AMF_ST_DATA   = 4'b1000,
		AMF_ST_PAD    = 4'b1001,
		AMF_ST_TRAIL  = 4'b1010,
		AMF_ST_WAIT   = 4'b1011
	} amf_state_e;
	typedef logic [15:0] amf_len_t;
endpackage : amf_pkg

// ---- logic/amf_track_writer.sv ----
`timescale 1ns/1ns
`include "amf_map.svh"
module amf_track_writer
	import amf_pkg::*;
#(
	parameter amf_len_t ID_LEN   = 16'd8,    // identifier_length
	parameter amf_len_t DATA_LEN = 16'd512   // data and check length
) (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	// user control
	input  wire logic       start,       // one-cycle request to write a track or sector
	input  wire logic       update_only, // format C only: skip fields through the splice byte
	input  wire logic       use_header,  // emit the optional track header first, except in a format C update
	input  wire amf_fmt_e   fmt,
	input  wire logic [7:0] user_byte,   // identifier or data byte, taken on user_take
	output logic            user_take,   // pulse: user_byte consumed this byte
	output logic            busy,
	output logic [15:0]     max_sectors, // capacity for fmt and lengths
	// drive pins
	input  wire logic       byte_clk,    // drive byte clock, asynchronous
	input  wire logic       index_in,    // drive index pulse
	output logic            write_gate,
	output logic            erase_cmd,   // drive makes the mark erasure
	output logic [7:0]      write_byte
);
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [1:0] bclk_sync_q;  // byte clock sync chain
	logic [1:0] idx_sync_q;   // index sync chain
	logic       bclk_old_q;   // previous synced byte clock
	logic       byte_tick;    // one pulse per drive byte
	// two flops before anything looks at pins
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			bclk_sync_q <= 2'b00;
			idx_sync_q  <= 2'b00;
			bclk_old_q  <= 1'b0;
		end else begin
			bclk_sync_q <= {bclk_sync_q[0], byte_clk};
			idx_sync_q  <= {idx_sync_q[0], index_in};
			bclk_old_q  <= bclk_sync_q[1];
		end
	end
	assign byte_tick = bclk_sync_q[1] & ~bclk_old_q;
	// ************************************************************
	// capacity
	// ************************************************************
	amf_len_t oh_sec;  // per_sector_overhead
	amf_len_t oh_trk;  // track overhead
	amf_len_t hdr_len; // header bytes
	// header length = fixed fields + identifier
	always_comb begin
		case (fmt)
			AMF_FMT_C: oh_sec = `AMF_OH_C;
			AMF_FMT_D: oh_sec = `AMF_OH_D;
			AMF_FMT_E: oh_sec = `AMF_OH_E;
			default:   oh_sec = `AMF_OH_F;
		endcase
		oh_trk  = fmt[1] ? `AMF_TRK_OH_EF : `AMF_TRK_OH_CD;
		hdr_len = use_header ? (`AMF_HDR_PRE_LEN + `AMF_ERASE_LEN + `AMF_LOCK_LEN +
			`AMF_SYNC_LEN + ID_LEN + `AMF_HDR_PAD_LEN) : 16'd0;
	end
	// divide is slow and is re-evaluated on every clk_sys cycle
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			max_sectors <= 16'd0;
		end else begin
			max_sectors <= 16'((`AMF_TRACK_LEN - oh_trk - hdr_len) /
				(oh_sec + ID_LEN + DATA_LEN));
		end
	end
	// ************************************************************
	// field sequencer
	// ************************************************************
	amf_state_e state_q;
	amf_len_t   cnt_q;      // bytes left in current field
	logic       hdr_q;      // currently in track header
	amf_fmt_e   fmt_q;      // latched format
	logic       upd_q;      // latched update_only
	logic       ilv;        // interlaced layout
	logic       rewrite;    // identifier rides in data field
	// interlaced layouts leave no room for back-to-back sectors; the host spaces them
	assign ilv     = fmt_q[1];
	assign rewrite = fmt_q[0];
	// field walk, one step per drive byte
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_q <= AMF_ST_IDLE;
			cnt_q   <= 16'd0;
			hdr_q   <= 1'b0;
			fmt_q   <= AMF_FMT_C;
			upd_q   <= 1'b0;
		end else if (state_q == AMF_ST_IDLE) begin
			if (start) begin
				fmt_q   <= fmt;
				upd_q   <= update_only;
				// a format C update starts after the splice, so it never carries a header
				hdr_q   <= use_header && !(update_only && fmt == AMF_FMT_C);
				state_q <= AMF_ST_WAIT;
			end
		end else if (state_q == AMF_ST_WAIT) begin
			// fields open only on a byte tick, else the first byte would be cut short
			if (byte_tick && upd_q && fmt_q == AMF_FMT_C) begin
				state_q <= AMF_ST_RELOCK;
				cnt_q   <= `AMF_RELOCK_LEN;
			end else if (byte_tick && idx_sync_q[1]) begin
				state_q <= hdr_q ? AMF_ST_PRE : AMF_ST_ERASE;  // orient on index
				cnt_q   <= hdr_q ? `AMF_HDR_PRE_LEN : `AMF_ERASE_LEN;
			end
		end else if (byte_tick) begin
			if (cnt_q > 16'd1) begin
				cnt_q <= cnt_q - 16'd1;
			end else begin
				case (state_q)
					AMF_ST_PRE: begin
						state_q <= AMF_ST_ERASE;
						cnt_q   <= `AMF_ERASE_LEN;
					end
					AMF_ST_ERASE: begin
						if (hdr_q || (!ilv && !rewrite)) begin
							state_q <= AMF_ST_LOCK;
							cnt_q   <= `AMF_LOCK_LEN;
						end else if (ilv) begin
							state_q <= AMF_ST_SPLICE;
							cnt_q   <= `AMF_SPLICE_LEN;
						end else begin
							state_q <= AMF_ST_DATA;
							cnt_q   <= ID_LEN + DATA_LEN;
						end
					end
					AMF_ST_SPLICE: begin
						if (ilv) begin
							state_q <= rewrite ? AMF_ST_DATA : AMF_ST_LOCK;
							cnt_q   <= rewrite ? ID_LEN + DATA_LEN : `AMF_LOCK_LEN;
						end else begin
							state_q <= AMF_ST_RELOCK;
							cnt_q   <= `AMF_RELOCK_LEN;
						end
					end
					AMF_ST_LOCK: begin
						state_q <= AMF_ST_SYNC;
						cnt_q   <= `AMF_SYNC_LEN;
					end
					AMF_ST_SYNC: begin
						state_q <= AMF_ST_IDENT;
						cnt_q   <= ID_LEN;
					end
					AMF_ST_IDENT: begin
						if (hdr_q) begin
							state_q <= AMF_ST_PAD;
							cnt_q   <= `AMF_HDR_PAD_LEN;
						end else if (ilv) begin
							state_q <= AMF_ST_RELOCK;
							cnt_q   <= `AMF_RELOCK_LEN;
						end else begin
							state_q <= AMF_ST_SPLICE;
							cnt_q   <= `AMF_SPLICE_LEN;
						end
					end
					AMF_ST_RELOCK: begin
						state_q <= AMF_ST_DATA;
						cnt_q   <= DATA_LEN;
					end
					AMF_ST_DATA: begin
						state_q <= AMF_ST_PAD;
						cnt_q   <= ilv ? `AMF_PAD_ILV_LEN : `AMF_PAD_SEQ_LEN;
					end
					AMF_ST_PAD: begin
						if (hdr_q) begin
							hdr_q   <= 1'b0;  // header done, first sector follows
							state_q <= AMF_ST_ERASE;
							cnt_q   <= `AMF_ERASE_LEN;
						end else begin
							state_q <= AMF_ST_TRAIL;
							cnt_q   <= ilv ? `AMF_TRAIL_ILV_LEN : `AMF_TRAIL_SEQ_LEN;
						end
					end
					default: begin
						state_q <= AMF_ST_IDLE;  // trailer finished
						cnt_q   <= 16'd0;
					end
				endcase
			end
		end
	end
	// ************************************************************
	// pin outputs
	// ************************************************************
	// registered drive of bytes, gate and erasure request
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			write_byte <= `AMF_ZERO_BYTE;
			write_gate <= 1'b0;
			erase_cmd  <= 1'b0;
			user_take  <= 1'b0;
			busy       <= 1'b0;
		end else begin
			busy       <= (state_q != AMF_ST_IDLE);
			write_gate <= (state_q != AMF_ST_IDLE) && (state_q != AMF_ST_WAIT)
				&& (state_q != AMF_ST_ERASE);
			erase_cmd  <= (state_q == AMF_ST_ERASE);
			user_take  <= byte_tick && ((state_q == AMF_ST_IDENT) ||
				(state_q == AMF_ST_DATA));
			case (state_q)
				AMF_ST_SYNC:  write_byte <= `AMF_ONES_BYTE;
				AMF_ST_IDENT: write_byte <= user_byte;
				AMF_ST_DATA:  write_byte <= user_byte;
				default:      write_byte <= `AMF_ZERO_BYTE;
			endcase
		end
	end
	// ************************************************************
	// checks
	// ************************************************************
	sequence s_ident_end;
		byte_tick && state_q == AMF_ST_IDENT && cnt_q == 16'd1 && !hdr_q && !ilv;
	endsequence
	a_splice_after_id: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_ident_end |=> state_q == AMF_ST_SPLICE)
		else $error("splice did not follow identifier");
	a_trail_len_seq: assert property (@(posedge clk_sys) disable iff (!rstn)
		(byte_tick && state_q == AMF_ST_PAD && !hdr_q && !ilv && cnt_q == 16'd1)
		|=> cnt_q == 16'd15)
		else $error("sequential trailer length wrong");
	a_start_waits: assert property (@(posedge clk_sys) disable iff (!rstn)
		(state_q == AMF_ST_IDLE && start) |=> state_q == AMF_ST_WAIT)
		else $error("start did not wait for alignment");
	a_update_skip: assert property (@(posedge clk_sys) disable iff (!rstn)
		(byte_tick && state_q == AMF_ST_WAIT && upd_q && fmt_q == AMF_FMT_C)
		|=> state_q == AMF_ST_RELOCK)
		else $error("update did not skip to relock");
	a_d_no_lock: assert property (@(posedge clk_sys) disable iff (!rstn)
		(fmt_q == AMF_FMT_D && !hdr_q) |-> state_q != AMF_ST_LOCK)
		else $error("lock field in rewrite format");
	a_ilv_splice: assert property (@(posedge clk_sys) disable iff (!rstn)
		(byte_tick && state_q == AMF_ST_ERASE && cnt_q == 16'd1 && ilv && !hdr_q)
		|=> state_q == AMF_ST_SPLICE)
		else $error("interlaced splice misplaced");
	a_erase_pin: assert property (@(posedge clk_sys) disable iff (!rstn)
		state_q == AMF_ST_ERASE |=> erase_cmd && !write_gate)
		else $error("erasure command not raised");
	a_sync_ones: assert property (@(posedge clk_sys) disable iff (!rstn)
		state_q == AMF_ST_SYNC |=> write_byte == 8'hff)
		else $error("sync byte not ones");
	a_hdr_pad: assert property (@(posedge clk_sys) disable iff (!rstn)
		(byte_tick && state_q == AMF_ST_IDENT && cnt_q == 16'd1 && hdr_q)
		|=> state_q == AMF_ST_PAD ##0 cnt_q == 16'd1)
		else $error("header pad missing");
endmodule : amf_track_writer
